// ---- sss_sequencer.v ----
// Step setpoint sequencer: step table, ramp/hold walk, remaining-time readout
//
// What this block does
// R01: Hold time unit 0.1 s, 1 s, 1 min
// R02: Readout in step unit, min.s or h.min
// R03: 1 s unit: clamp readout at 99.99
// R04: 1 min unit: clamp readout at 99.99
// R05: PV start none begins at step 1 hold
// R06: Up start ramps from PV if below
// R07: Down start ramps from PV if above
// R08: End stop: final hold done goes READY
// R09: End loop returns to step 1 ramp
// R10: Loop ramp from final setpoint, ignores PV start
// R11: Loop repeats without limit until READY
// R12: End hold keeps final setpoint until READY
// R13: Per-step tuning group 1 to 8
// R14: Ramp rate 0.1 to 999.9, zero none
// R15: Zero rate or equal setpoints skip ramp
// R16: Zero step time skips hold portion
// R17: Ramp unit per s, min, h; default min
// R18: Active steps 1 to 8; last is final
// R19: Hold countdown per unit tick, zero advances
`timescale 1ns/1ps
`default_nettype none
`include "sss_defs.vh"

module sss_sequencer #(
  parameter TENTH_CYCLES = `SSS_TENTH_S_NS / `SSS_CLK_PERIOD_NS
) (
  input  wire        clk_i,
  input  wire        srst_i,
  input  wire [7:0]  addr_i,
  input  wire [15:0] wr_data_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [15:0] rd_data_o,
  input  wire [15:0] process_value_i,
  output reg  [15:0] local_setpoint_o,
  output reg  [3:0]  tuning_group_o,
  output reg  [15:0] remain_disp_o,
  output reg  [2:0]  step_o,
  output reg         ramp_active_o,
  output reg         hold_portion_o,
  output reg         run_o
);

  localparam [2:0] ST_READY   = 3'h0;
  localparam [2:0] ST_RAMP_IN = 3'h1;
  localparam [2:0] ST_RAMP    = 3'h2;
  localparam [2:0] ST_HOLD_IN = 3'h3;
  localparam [2:0] ST_HOLD    = 3'h4;
  localparam [2:0] ST_NEXT    = 3'h5;
  localparam [2:0] ST_KEEP    = 3'h6;

  reg        [1:0]  tu_ff;
  reg        [1:0]  pvs_ff;
  reg        [1:0]  end_ff;
  reg        [1:0]  ru_ff;
  reg        [3:0]  steps_ff;
  reg signed [15:0] sp_mem   [0:7];
  reg        [3:0]  grp_mem  [0:7];
  reg        [15:0] rate_mem [0:7];
  reg        [13:0] time_mem [0:7];
  reg        [2:0]  state_ff;
  reg        [2:0]  step_ff;
  reg signed [19:0] acc_ff;
  reg               up_ff;
  reg        [13:0] rem_ff;
  reg               run_ff;
  integer           i;

  // Timebase chain: 0.1 s, 1 s, 1 min, 1 h
  wire t_tenth;
  wire t_sec;
  wire t_min;
  wire t_hour;

  sss_tick_div #(.DIV(TENTH_CYCLES)) u_div_tenth (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .tick_i (1'b1),
    .tick_o (t_tenth)
  );
  sss_tick_div #(.DIV(`SSS_TENTHS_PER_S)) u_div_sec (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .tick_i (t_tenth),
    .tick_o (t_sec)
  );
  sss_tick_div #(.DIV(`SSS_S_PER_MIN)) u_div_min (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .tick_i (t_sec),
    .tick_o (t_min)
  );
  sss_tick_div #(.DIV(`SSS_MIN_PER_H)) u_div_hour (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .tick_i (t_min),
    .tick_o (t_hour)
  );

  // R01 hold unit tick
  wire hold_tick = (tu_ff == `SSS_TU_TENTH) ? t_tenth :
                   (tu_ff == `SSS_TU_SEC)   ? t_sec   : t_min;
  // R17 ramp unit tick
  wire ramp_tick = (ru_ff == `SSS_RU_SEC) ? t_sec :
                   (ru_ff == `SSS_RU_MIN) ? t_min : t_hour;

  function signed [19:0] x10;
    input signed [15:0] v;
    reg signed [19:0] e;
    begin
      e   = {{4{v[15]}}, v};
      x10 = (e <<< 3) + (e <<< 1);
    end
  endfunction

  // R18 final step index
  wire        [2:0]  last_step = steps_ff[2:0] - 3'h1;
  wire signed [19:0] tgt       = x10(sp_mem[step_ff]);
  wire signed [19:0] pv10      = x10($signed(process_value_i));
  wire signed [19:0] rate      = {4'h0, rate_mem[step_ff]};
  wire signed [19:0] up_next   = acc_ff + rate;
  wire signed [19:0] dn_next   = acc_ff - rate;
  wire signed [19:0] sp_whole  = acc_ff / 20'sd10;
  wire               sw_ctrl   = wr_i && (addr_i == `SSS_REG_CTRL);
  wire               tbl_hit   = (addr_i[7:5] == `SSS_TBL_HI);
  wire        [2:0]  tbl_idx   = addr_i[4:2];

  // Sequencer walk and run mode
  always @(posedge clk_i) begin
    if (srst_i) begin
      state_ff <= ST_READY;
      step_ff  <= 3'h0;
      acc_ff   <= 20'sh0;
      up_ff    <= 1'b0;
      rem_ff   <= 14'h0;
      run_ff   <= 1'b0;
    end else begin
      if (sw_ctrl) begin
        run_ff <= wr_data_i[0];
      end
      if (!run_ff) begin
        // READY: parked at top of step 1
        state_ff <= ST_READY;
        step_ff  <= 3'h0;
        acc_ff   <= x10(sp_mem[0]);
        rem_ff   <= time_mem[0];
      end else begin
        case (state_ff)
          ST_READY: begin
            // R06 up start
            if (pvs_ff == `SSS_PVS_UP && $signed(process_value_i) < sp_mem[0]) begin
              acc_ff   <= pv10;
              state_ff <= ST_RAMP_IN;
            // R07 down start
            end else if (pvs_ff == `SSS_PVS_DOWN && $signed(process_value_i) > sp_mem[0]) begin
              acc_ff   <= pv10;
              state_ff <= ST_RAMP_IN;
            // R05 start at hold portion
            end else begin
              state_ff <= ST_HOLD_IN;
            end
          end
          ST_RAMP_IN: begin
            // R15 skip ramp
            if (rate_mem[step_ff] == 16'h0 || acc_ff == tgt) begin
              acc_ff   <= tgt;
              state_ff <= ST_HOLD_IN;
            end else begin
              up_ff    <= (acc_ff < tgt);
              state_ff <= ST_RAMP;
            end
          end
          ST_RAMP: begin
            // R14 ramp by rate tenths
            if (ramp_tick) begin
              if (up_ff ? (up_next >= tgt) : (dn_next <= tgt)) begin
                acc_ff   <= tgt;
                state_ff <= ST_HOLD_IN;
              end else begin
                acc_ff <= up_ff ? up_next : dn_next;
              end
            end
          end
          ST_HOLD_IN: begin
            rem_ff <= time_mem[step_ff];
            // R16 skip zero hold
            if (time_mem[step_ff] == 14'h0) begin
              state_ff <= ST_NEXT;
            end else begin
              state_ff <= ST_HOLD;
            end
          end
          ST_HOLD: begin
            // R19 count down
            if (hold_tick) begin
              rem_ff <= rem_ff - 14'h1;
              if (rem_ff == 14'h1) begin
                state_ff <= ST_NEXT;
              end
            end
          end
          ST_NEXT: begin
            if (step_ff != last_step) begin
              step_ff  <= step_ff + 3'h1;
              state_ff <= ST_RAMP_IN;
            // R09 loop
            end else if (end_ff == `SSS_END_LOOP) begin
              // R10 ramp from final setpoint
              // R11 unlimited repeats
              step_ff  <= 3'h0;
              state_ff <= ST_RAMP_IN;
            // R12 keep final setpoint
            end else if (end_ff == `SSS_END_HOLD) begin
              state_ff <= ST_KEEP;
            // R08 stop to READY
            end else begin
              state_ff <= ST_READY;
              if (!(sw_ctrl && wr_data_i[0])) begin
                run_ff <= 1'b0;
              end
            end
          end
          ST_KEEP: begin
            state_ff <= ST_KEEP;
          end
          default: begin
            state_ff <= ST_READY;
          end
        endcase
      end
    end
  end

  // Settings and step table writes
  always @(posedge clk_i) begin
    if (srst_i) begin
      tu_ff    <= `SSS_RST_TU;
      pvs_ff   <= `SSS_RST_PVS;
      end_ff   <= `SSS_RST_END;
      ru_ff    <= `SSS_RST_RU;
      steps_ff <= `SSS_RST_STEPS;
      for (i = 0; i < 8; i = i + 1) begin
        sp_mem[i]   <= `SSS_RST_SP;
        grp_mem[i]  <= `SSS_RST_GRP;
        rate_mem[i] <= `SSS_RST_RATE;
        time_mem[i] <= `SSS_RST_TIME;
      end
    end else if (wr_i) begin
      if (addr_i == `SSS_REG_CFG) begin
        // R01 hold unit select
        if (wr_data_i[`SSS_CFG_TU_LSB+1:`SSS_CFG_TU_LSB] <= `SSS_TU_MIN) begin
          tu_ff <= wr_data_i[`SSS_CFG_TU_LSB+1:`SSS_CFG_TU_LSB];
        end
        // R05 PV start select
        if (wr_data_i[`SSS_CFG_PVS_LSB+1:`SSS_CFG_PVS_LSB] <= `SSS_PVS_DOWN) begin
          pvs_ff <= wr_data_i[`SSS_CFG_PVS_LSB+1:`SSS_CFG_PVS_LSB];
        end
        // R08 end mode select
        if (wr_data_i[`SSS_CFG_END_LSB+1:`SSS_CFG_END_LSB] <= `SSS_END_HOLD) begin
          end_ff <= wr_data_i[`SSS_CFG_END_LSB+1:`SSS_CFG_END_LSB];
        end
        // R17 ramp unit select
        if (wr_data_i[`SSS_CFG_RU_LSB+1:`SSS_CFG_RU_LSB] <= `SSS_RU_HOUR) begin
          ru_ff <= wr_data_i[`SSS_CFG_RU_LSB+1:`SSS_CFG_RU_LSB];
        end
        // R18 step count 1 to 8
        if (wr_data_i[`SSS_CFG_STEPS_LSB+3:`SSS_CFG_STEPS_LSB] != 4'h0 &&
            {12'h0, wr_data_i[`SSS_CFG_STEPS_LSB+3:`SSS_CFG_STEPS_LSB]} <= `SSS_MAX_STEPS) begin
          steps_ff <= wr_data_i[`SSS_CFG_STEPS_LSB+3:`SSS_CFG_STEPS_LSB];
        end
      end else if (tbl_hit) begin
        if (addr_i[1:0] == `SSS_FLD_SP) begin
          sp_mem[tbl_idx] <= wr_data_i;
        // R13 group 1 to 8
        end else if (addr_i[1:0] == `SSS_FLD_GRP) begin
          if (wr_data_i != 16'h0 && wr_data_i <= `SSS_MAX_GRP) begin
            grp_mem[tbl_idx] <= wr_data_i[3:0];
          end
        // R14 rate limit
        end else if (addr_i[1:0] == `SSS_FLD_RATE) begin
          if (wr_data_i <= `SSS_MAX_RATE) begin
            rate_mem[tbl_idx] <= wr_data_i;
          end
        // R01 time range
        end else begin
          if (wr_data_i <= `SSS_MAX_TIME) begin
            time_mem[tbl_idx] <= wr_data_i[13:0];
          end
        end
      end
    end
  end

  // R02 readout source and format
  wire [13:0] disp_src = (state_ff == ST_HOLD) ? rem_ff : time_mem[step_ff];
  wire [13:0] disp_hi  = disp_src / 14'd60;
  wire [13:0] disp_lo  = disp_src % 14'd60;
  reg  [15:0] nxt_disp;

  always @* begin
    if (tu_ff == `SSS_TU_TENTH) begin
      nxt_disp = {2'h0, disp_src};
    // R03 R04 clamp at 99.99
    end else if (disp_src >= `SSS_DISP_CLAMP) begin
      nxt_disp = {`SSS_DISP_FULL, `SSS_DISP_FULL};
    end else begin
      nxt_disp = {disp_hi[7:0], disp_lo[7:0]};
    end
  end

  // Registered outputs and read port
  always @(posedge clk_i) begin
    if (srst_i) begin
      rd_data_o        <= 16'h0;
      local_setpoint_o <= 16'h0;
      tuning_group_o   <= `SSS_RST_GRP;
      remain_disp_o    <= 16'h0;
      step_o           <= 3'h0;
      ramp_active_o    <= 1'b0;
      hold_portion_o   <= 1'b0;
      run_o            <= 1'b0;
    end else begin
      local_setpoint_o <= sp_whole[15:0];
      // R13 group of current step
      tuning_group_o   <= grp_mem[step_ff];
      remain_disp_o    <= nxt_disp;
      step_o           <= step_ff;
      ramp_active_o    <= (state_ff == ST_RAMP);
      hold_portion_o   <= (state_ff == ST_HOLD);
      run_o            <= run_ff;
      rd_data_o        <= 16'h0;
      if (rd_i) begin
        if (addr_i == `SSS_REG_CTRL) begin
          rd_data_o <= {15'h0, run_ff};
        end else if (addr_i == `SSS_REG_CFG) begin
          rd_data_o <= {4'h0, steps_ff, ru_ff, end_ff, pvs_ff, tu_ff};
        end else if (addr_i == `SSS_REG_STATUS) begin
          rd_data_o <= {9'h0, state_ff, 1'b0, step_ff};
        end else if (addr_i == `SSS_REG_SETPOINT) begin
          rd_data_o <= sp_whole[15:0];
        end else if (addr_i == `SSS_REG_REMAIN) begin
          rd_data_o <= nxt_disp;
        end else if (addr_i == `SSS_REG_PV) begin
          rd_data_o <= process_value_i;
        end else if (tbl_hit) begin
          if (addr_i[1:0] == `SSS_FLD_SP) begin
            rd_data_o <= sp_mem[tbl_idx];
          end else if (addr_i[1:0] == `SSS_FLD_GRP) begin
            rd_data_o <= {12'h0, grp_mem[tbl_idx]};
          end else if (addr_i[1:0] == `SSS_FLD_RATE) begin
            rd_data_o <= rate_mem[tbl_idx];
          end else begin
            rd_data_o <= {2'h0, time_mem[tbl_idx]};
          end
        end
      end
    end
  end

endmodule // sss_sequencer

`default_nettype wire

// ---- sss_defs.vh ----
// Offsets, fields, reset values and timing constants of the step setpoint sequencer
`ifndef SSS_DEFS_VH
`define SSS_DEFS_VH

// Register offsets
`define SSS_REG_CTRL        8'h00
`define SSS_REG_CFG         8'h01
`define SSS_REG_STATUS      8'h02
`define SSS_REG_SETPOINT    8'h03
`define SSS_REG_REMAIN      8'h04
`define SSS_REG_PV          8'h05
// Step table: base + 4 * step + field
`define SSS_TBL_HI          3'h1
`define SSS_FLD_SP          2'h0
`define SSS_FLD_GRP         2'h1
`define SSS_FLD_RATE        2'h2
`define SSS_FLD_TIME        2'h3

// CFG field positions
`define SSS_CFG_TU_LSB      0
`define SSS_CFG_PVS_LSB     2
`define SSS_CFG_END_LSB     4
`define SSS_CFG_RU_LSB      6
`define SSS_CFG_STEPS_LSB   8

// Reset values
`define SSS_RST_TU          2'h0
`define SSS_RST_PVS         2'h0
`define SSS_RST_END         2'h0
`define SSS_RST_RU          2'h1
`define SSS_RST_STEPS       4'h1
`define SSS_RST_SP          16'h0000
`define SSS_RST_GRP         4'h1
`define SSS_RST_RATE        16'h0000
`define SSS_RST_TIME        14'h0000

// Encodings
`define SSS_TU_TENTH        2'h0
`define SSS_TU_SEC          2'h1
`define SSS_TU_MIN          2'h2
`define SSS_PVS_NONE        2'h0
`define SSS_PVS_UP          2'h1
`define SSS_PVS_DOWN        2'h2
`define SSS_END_STOP        2'h0
`define SSS_END_LOOP        2'h1
`define SSS_END_HOLD        2'h2
`define SSS_RU_SEC          2'h0
`define SSS_RU_MIN          2'h1
`define SSS_RU_HOUR         2'h2

// Limits
`define SSS_MAX_RATE        16'h270f
`define SSS_MAX_TIME        16'h270f
`define SSS_MAX_GRP         16'h0008
`define SSS_MAX_STEPS       16'h0008
`define SSS_DISP_CLAMP      14'h176f
`define SSS_DISP_FULL       8'h63

// Timing
`define SSS_CLK_PERIOD_NS   10
`define SSS_TENTH_S_NS      100000000
`define SSS_TENTHS_PER_S    10
`define SSS_S_PER_MIN       60
`define SSS_MIN_PER_H       60

`endif

// ---- sss_tick_div.v ----
// Pulse divider: one output pulse per DIV input pulses
`timescale 1ns/1ps
`default_nettype none

module sss_tick_div #(
  parameter DIV = 10
) (
  input  wire clk_i,
  input  wire srst_i,
  input  wire tick_i,
  output reg  tick_o
);

  localparam [26:0] LAST = DIV[26:0] - 27'h1;

  reg [26:0] cnt_ff;

  always @(posedge clk_i) begin
    if (srst_i) begin
      cnt_ff <= 27'h0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (tick_i) begin
        if (cnt_ff == LAST) begin
          cnt_ff <= 27'h0;
          tick_o <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + 27'h1;
        end
      end
    end
  end

endmodule // sss_tick_div

`default_nettype wire

// ---- sss_pv_model.sv ----
// Process value source standing in for the measured input
`timescale 1ns/1ps
`default_nettype none

module sss_pv_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] pv_set_i,
  output var  logic [15:0] process_value_o
);
  always @(posedge clk_i) process_value_o <= pv_set_i;
endmodule // sss_pv_model

`default_nettype wire

// ---- sss_seq_properties.sv ----
// Port-level checker for the step setpoint sequencer
`timescale 1ns/1ps
`default_nettype none

module sss_seq_checker (
  input wire logic        clk_i,
  input wire logic        srst_i,
  input wire logic [7:0]  addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [15:0] rd_data_o,
  input wire logic [15:0] process_value_i,
  input wire logic [15:0] local_setpoint_o,
  input wire logic [3:0]  tuning_group_o,
  input wire logic [15:0] remain_disp_o,
  input wire logic [2:0]  step_o,
  input wire logic        ramp_active_o,
  input wire logic        hold_portion_o,
  input wire logic        run_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_rd_idle: assert property (!$past(rd_i) |-> rd_data_o == 16'h0000)
    else $error("read data outside its slot");
  a_unmapped_read: assert property (rd_i && addr_i == 8'h10 |=> rd_data_o == 16'h0000)
    else $error("unmapped read not zero");
  a_pv_read: assert property (rd_i && addr_i == 8'h05 |=> rd_data_o == $past(process_value_i))
    else $error("process value read wrong");
  a_run_write: assert property (wr_i && addr_i == 8'h00 |=> ##1 run_o == $past(wr_data_i[0], 2))
    else $error("run mode not following write");
  a_ready_idle: assert property (!run_o && !$past(run_o) && !$past(run_o, 2) |->
    !ramp_active_o && !hold_portion_o) else $error("activity in ready mode");
  a_group_range: assert property (tuning_group_o inside {[4'h1:4'h8]})
    else $error("tuning group out of range");
  a_remain_width: assert property (remain_disp_o <= 16'h270f || remain_disp_o == 16'h6363 ||
    (remain_disp_o[15:8] <= 8'h63 && remain_disp_o[7:0] <= 8'h3b))
    else $error("readout beyond its range");
  a_ramp_hold_excl: assert property (!(ramp_active_o && hold_portion_o))
    else $error("ramp and hold together");
  a_hold_const: assert property (hold_portion_o && $past(hold_portion_o) |->
    $stable(local_setpoint_o)) else $error("setpoint moved in hold");
endmodule // sss_seq_checker

bind sss_sequencer sss_seq_checker u_chk (
  .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
  .rd_i(rd_i), .rd_data_o(rd_data_o), .process_value_i(process_value_i),
  .local_setpoint_o(local_setpoint_o), .tuning_group_o(tuning_group_o),
  .remain_disp_o(remain_disp_o), .step_o(step_o), .ramp_active_o(ramp_active_o),
  .hold_portion_o(hold_portion_o), .run_o(run_o)
);

`default_nettype wire

// ---- sss_testbench.sv ----
// Self-checking bench for the step setpoint sequencer
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        clk_i, srst_i, wr_i, rd_i, ramp_active_o, hold_portion_o, run_o;
  logic [7:0]  addr_i;
  logic [15:0] wr_data_i, rd_data_o, process_value_i, pv_set, local_setpoint_o, remain_disp_o, rv;
  logic [3:0]  tuning_group_o;
  logic [2:0]  step_o;
  int          fail_count, comparisons, n, i;
  logic [15:0] cf [6] = '{16'h0104, 16'h0108, 16'h0104, 16'h0108, 16'h0104, 16'h0100};
  logic [15:0] pvv [6] = '{16'd50, 16'd150, 16'd150, 16'd50, 16'd50, 16'd50};
  logic [15:0] rt [6] = '{16'd100, 16'd100, 16'd100, 16'd100, 16'd0, 16'd100};
  logic [15:0] lo [6] = '{16'd50, 16'd140, 16'd100, 16'd100, 16'd100, 16'd100};
  logic [15:0] cu [6] = '{16'h0104, 16'h0105, 16'h0105, 16'h0105, 16'h0106, 16'h0106};
  logic [15:0] tt [6] = '{16'd999, 16'd61, 16'd5998, 16'd5999, 16'd125, 16'd5999};
  logic [15:0] ex [6] = '{16'h03e7, 16'h0101, 16'h633a, 16'h6363, 16'h0205, 16'h6363};

  sss_pv_model u_pv (.clk_i(clk_i), .pv_set_i(pv_set), .process_value_o(process_value_i));

  sss_sequencer #(.TENTH_CYCLES(4)) uut (
    .clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
    .rd_i(rd_i), .rd_data_o(rd_data_o), .process_value_i(process_value_i),
    .local_setpoint_o(local_setpoint_o), .tuning_group_o(tuning_group_o),
    .remain_disp_o(remain_disp_o), .step_o(step_o), .ramp_active_o(ramp_active_o),
    .hold_portion_o(hold_portion_o), .run_o(run_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk1(input string nm, input logic s, input logic e);
    chk(nm, {15'h0, s}, {15'h0, e});
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rv = rd_data_o;
  endtask

  // Kinds: 0 hold, 1 ramp or hold, 2 ready, 3 hold of step 2, 4 ramp of step 1
  task automatic wait_for(input int k, input int lim);
    for (n = 0; n < lim; n++) begin
      @(posedge clk_i);
      #1;
      if (k == 0 && hold_portion_o === 1'b1) break;
      if (k == 1 && (hold_portion_o | ramp_active_o) === 1'b1) break;
      if (k == 2 && run_o === 1'b0) break;
      if (k == 3 && step_o === 3'h1 && hold_portion_o === 1'b1) break;
      if (k == 4 && step_o === 3'h0 && ramp_active_o === 1'b1) break;
    end
    if (n == lim) chk("wait bound", 16'h0001, 16'h0000);
  endtask

  task automatic stop_run();
    wr(8'h00, 16'h0000);
    repeat (2) @(posedge clk_i);
    #1;
    chk1("ready", run_o, 1'b0);
    chk("ready sp", local_setpoint_o, 16'd100);
  endtask

  task automatic final_report();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #300000;
    fail_count++;
    final_report();
  end

  initial begin
    srst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 8'h00;
    wr_data_i = 16'h0000;
    pv_set = 16'h0000;
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(8'h01); chk("cfg reset", rv, 16'h0140);
    rd(8'h21); chk("group reset", rv, 16'h0001);
    rd(8'h10); chk("unmapped", rv, 16'h0000);
    wr(8'h01, 16'h0940); rd(8'h01); chk("steps limit", rv, 16'h0140);
    wr(8'h21, 16'h0009); wr(8'h21, 16'h0005); rd(8'h21); chk("group", rv, 16'h0005);
    wr(8'h20, 16'd100); wr(8'h23, 16'd20); wr(8'h00, 16'h0001); wait_for(0, 10);
    chk("group out", {12'h0, tuning_group_o}, 16'h0005);
    chk("none start sp", local_setpoint_o, 16'd100);
    wait_for(2, 200); chk1("hold length", n >= 72 && n <= 92, 1'b1);
    for (i = 0; i < 6; i++) begin
      wr(8'h01, cf[i]); wr(8'h22, rt[i]); pv_set <= pvv[i]; wr(8'h00, 16'h0001);
      wait_for(1, 10);
      chk1("start ramp", ramp_active_o, lo[i] != 16'd100);
      chk1("start sp", local_setpoint_o >= lo[i] && local_setpoint_o <= lo[i] + 16'd10, 1'b1);
      wait_for(0, 400); chk("ramp end sp", local_setpoint_o, 16'd100);
      stop_run();
    end
    wr(8'h01, 16'h0044); wr(8'h22, 16'd250); wr(8'h00, 16'h0001); wait_for(1, 10);
    chk1("min ramp on", ramp_active_o, 1'b1);
    wait_for(0, 5000); chk1("ramp per min", n >= 2390 && n <= 4810, 1'b1);
    chk("per min sp", local_setpoint_o, 16'd100);
    stop_run();
    rd(8'h05); chk("pv read", rv, 16'd50);
    wr(8'h22, 16'd1);
    for (i = 0; i < 6; i++) begin
      wr(8'h01, cu[i]); wr(8'h23, tt[i]); wr(8'h00, 16'h0001); wait_for(1, 10);
      rd(8'h04); chk("remain", rv, ex[i]);
      chk("remain out", remain_disp_o, ex[i]);
      stop_run();
    end
    wr(8'h01, 16'h0214); wr(8'h22, 16'd100); wr(8'h23, 16'd4);
    wr(8'h24, 16'd200); wr(8'h26, 16'd100); wr(8'h27, 16'd4); pv_set <= 16'd0;
    wr(8'h00, 16'h0001);
    repeat (2) begin
      wait_for(3, 1500); wait_for(4, 100);
      chk1("loop sp", local_setpoint_o >= 16'd190 && local_setpoint_o <= 16'd200, 1'b1);
      chk1("loop run", run_o, 1'b1);
    end
    stop_run();
    wr(8'h01, 16'h0224); wr(8'h00, 16'h0001); wait_for(3, 1500);
    repeat (100) @(posedge clk_i);
    #1;
    chk1("keep run", run_o, 1'b1);
    chk("keep sp", local_setpoint_o, 16'd200);
    chk("keep step", {13'h0, step_o}, 16'h0001);
    stop_run();
    wr(8'h01, 16'h0100); wr(8'h23, 16'h0000); wr(8'h00, 16'h0001); wait_for(2, 10);
    chk("zero hold skip", n[15:0], 16'd3);
    final_report();
  end
endmodule // testbench

`default_nettype wire
